// [rtl/mb_params.svh]
`ifndef MB_PARAMS_SVH
`define MB_PARAMS_SVH
`define CLK_HZ      32'h02FA_F080
`define FC_RD       8'h03
`define FC_WR1      8'h06
`define FC_WRN      8'h10
`define EXC_BIT     8'h80
`define EX_FUNC     8'h01
`define EX_ADDR     8'h02
`define EX_VAL      8'h03
`define EX_FAIL     8'h04
`define MAX_RD      16'h007D
`define MAX_WR      16'h007B
`define TCP_MAX     9'h104
`define TCP_HDR     9'h007
`define SER_HDR     9'h001
`define STD_PORT    16'h01F6
`define UPORT_MIN   16'h2710
`define UPORT_DEF   16'h2710
`define CONN_ALL    3'h4
`define CONN_HALF   3'h2
`define SUP_STEP_MS 32'h0000_0064
`define SUP_DEF     16'h0258
`define STA_DEF     8'h01
`define STA_MAX     8'hF7
`define BCAST       8'h00
`define CHAR_BITS   64'h0B
`define SIL_X2      64'h07
`define CRC_INIT    16'hFFFF
`define CRC_POLY    16'hA001
`define MONTH_MAX   8'h0C
`define NREG        16
`define RO_MASK     16'h00FF
`define CONT_MASK   16'h0EAA
`define DT_MON      4'h9
`define A_CFG       8'h00
`define A_UPORT     8'h04
`define A_STA       8'h08
`define A_SUP       8'h0C
`define A_STAT      8'h10
`define A_HREG      2'h1
`define F_UEN       0
`define F_RO_STD    1
`define F_RO_USR    2
`define F_RO_SER    3
`define F_PAR       4
`define F_BAUD      8
`define CFG_DEF     16'h0410
`endif

// [rtl/mb_pkg.sv]
package mb_pkg;
`include "mb_params.svh"
	typedef enum logic [1:0] {PAR_NONE1, PAR_EVEN, PAR_ODD, PAR_NONE2} parity_t;
	typedef enum {S_RX, S_CHK, S_EXEC, S_GAP, S_TX} srv_state_t;
	typedef enum {C_IDLE, C_TX, C_WAIT, C_GAP} cli_state_t;

	function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
		return r;
	endfunction

	function automatic logic [31:0] baud_hz(input logic [2:0] code);
		logic [31:0] r;
		r = 32'h0000_04B0;
		r = r << code;
		if (code >= 3'h6)
			r = (code == 3'h6) ? 32'h0000_E100 : 32'h0001_C200;
		return r;
	endfunction
endpackage

// [rtl/mb_link.sv]
`timescale 1ns/1ps
interface mb_link;
	logic        conn_req;
	logic [15:0] conn_port;
	logic        conn_rel;
	logic [1:0]  conn_rel_id;
	logic        conn_ack;
	logic        conn_nak;
	logic [1:0]  conn_id;
	logic        srv_rdy;
	logic        req_valid;
	logic [7:0]  req_data;
	logic        req_last;
	logic        req_ser;
	logic [1:0]  req_conn;
	logic        rsp_valid;
	logic [7:0]  rsp_data;
	logic        rsp_last;
	modport srv (input conn_req, conn_port, conn_rel, conn_rel_id, req_valid, req_data,
		req_last, req_ser, req_conn, output conn_ack, conn_nak, conn_id, srv_rdy,
		rsp_valid, rsp_data, rsp_last);
	modport cli (output conn_req, conn_port, conn_rel, conn_rel_id, req_valid, req_data,
		req_last, req_ser, req_conn, input conn_ack, conn_nak, conn_id, srv_rdy,
		rsp_valid, rsp_data, rsp_last);
endinterface

// [rtl/modbus_server.sv]
`timescale 1ns/1ps
`include "mb_params.svh"
module modbus_server
	import mb_pkg::*;
#(
	parameter int CLK_HZ       = `CLK_HZ,
	parameter int SUP_STEP_CYC = `CLK_HZ / 1000 * `SUP_STEP_MS,
	parameter int NREG         = `NREG
)(
	input  wire logic        clk,
	input  wire logic        rst_b,
	mb_link.srv              lnk,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	output logic      [1:0]  ser_parity,
	output logic      [2:0]  ser_baud
);
	if (NREG < 12 || NREG > 16)
	begin
		$error("NREG must lie in 12..16");
	end

	// =====================================================
	// silence table, one entry per baud code
	function automatic logic [255:0] sil_tab();
		logic [255:0] t;
		logic [63:0]  b2;
		t = '0;
		for (int i = 0; i < 8; i++)
		begin
			b2 = 64'(baud_hz(3'(i))) << 1;
			t[32*i +: 32] = 32'((64'(CLK_HZ) * `CHAR_BITS * `SIL_X2 + b2 - 64'h1) / b2);
		end
		return t;
	endfunction
	localparam logic [255:0] SIL = sil_tab();

	srv_state_t  st_q;
	logic [7:0]  buf_q [0:`TCP_MAX-1];
	logic [15:0] hreg_q [0:NREG-1];
	logic [8:0]  rx_n_q, tx_i_q;
	logic        ovf_q, ser_q, sup_to_q;
	logic [1:0]  conn_q;
	logic [15:0] crc_q, cfg_q, uport_q, sup_q, steps_q;
	logic [7:0]  exc_q, wi_q, sta_q, last_exc_q;
	logic [31:0] gap_q, tick_q;
	logic [3:0]  used_q, usr_q;
	logic [7:0]  exc_d, tx_b;
	logic [15:0] inr;
	logic [2:0]  n_std, n_usr;
	logic [1:0]  free;
	logic        has_free;

	// =====================================================
	// request fields
	wire [15:0] cont_m = `CONT_MASK;
	wire [15:0] ro_m   = `RO_MASK;
	wire [8:0]  h      = ser_q ? `SER_HDR : `TCP_HDR;
	wire [7:0]  fc     = buf_q[h];
	wire [15:0] ra     = {buf_q[h + 9'h001], buf_q[h + 9'h002]};
	wire        is_rd  = fc == `FC_RD;
	wire        is_w1  = fc == `FC_WR1;
	wire        is_wn  = fc == `FC_WRN;
	wire        is_wr  = is_w1 | is_wn;
	wire [15:0] qty    = is_w1 ? 16'h0001 : {buf_q[h + 9'h003], buf_q[h + 9'h004]};
	wire [7:0]  bcnt   = buf_q[h + 9'h005];
	wire [8:0]  dof    = is_w1 ? h + 9'h003 : h + 9'h006;
	wire [16:0] aend   = {1'b0, ra} + {1'b0, qty};
	wire [8:0]  mon_at = dof + 9'({4'(`DT_MON - ra[3:0]), 1'b0}) + 9'h001;
	wire [7:0]  mon    = buf_q[mon_at];
	wire        ro_now = ser_q ? cfg_q[`F_RO_SER] :
		usr_q[conn_q] ? cfg_q[`F_RO_USR] : cfg_q[`F_RO_STD];
	wire        part   = cont_m[ra[3:0]] | (aend < 17'(NREG) && cont_m[aend[3:0]]);
	wire        crc_ok = ser_q ? (crc_q == 16'h0000) : 1'b1;
	wire        for_us = !ser_q || buf_q[0] == sta_q || buf_q[0] == `BCAST;
	wire        bcast  = ser_q && buf_q[0] == `BCAST;
	wire        good   = !ovf_q && crc_ok && for_us && rx_n_q > h;

	always_comb
	begin
		inr = '0;
		for (int i = 0; i < 16; i++)
			inr[i] = (i < NREG) && (17'(i) >= {1'b0, ra}) && (17'(i) < aend);
	end

	always_comb
	begin
		exc_d = 8'h00;
		if (!is_rd && !is_wr)
			exc_d = `EX_FUNC;
		else if (qty == 16'h0000 || qty > (is_rd ? `MAX_RD : `MAX_WR) || aend > 17'(NREG))
			exc_d = `EX_ADDR;
		else if (is_wr && |(inr & ro_m))
			exc_d = `EX_ADDR;
		else if (part || (is_wr && ro_now) || (is_wn && {8'h00, bcnt} != {qty[14:0], 1'b0}))
			exc_d = `EX_VAL;
		else if (is_wr && inr[`DT_MON] && (mon == 8'h00 || mon > `MONTH_MAX))
			exc_d = `EX_FAIL;
	end

	// =====================================================
	// response bytes
	wire [8:0]  plen  = exc_q != 8'h00 ? 9'h002 : is_rd ? 9'h002 + {qty[7:0], 1'b0} : 9'h005;
	wire [8:0]  pend  = h + plen;
	wire [8:0]  tlen  = ser_q ? pend + 9'h002 : pend;
	wire [8:0]  k     = tx_i_q - h;
	wire [7:0]  ri    = ra[7:0] + k[8:1] - 8'h01;
	wire [15:0] rword = hreg_q[ri[3:0]];
	wire [3:0]  wa    = ra[3:0] + wi_q[3:0];
	wire [8:0]  wb    = dof + 9'({wi_q, 1'b0});
	wire        w_end = {8'h00, wi_q} == qty - 16'h0001;

	always_comb
	begin
		if (tx_i_q < h)
			tx_b = (!ser_q && tx_i_q == 9'h004) ? 8'h00 :
				(!ser_q && tx_i_q == 9'h005) ? 8'(plen + 9'h001) : buf_q[tx_i_q];
		else if (tx_i_q >= pend)
			tx_b = tx_i_q == pend ? crc_q[7:0] : crc_q[15:8];
		else if (exc_q != 8'h00)
			tx_b = k == 9'h000 ? (fc | `EXC_BIT) : exc_q;
		else if (!is_rd)
			tx_b = buf_q[tx_i_q];
		else if (k == 9'h000)
			tx_b = fc;
		else if (k == 9'h001)
			tx_b = {qty[6:0], 1'b0};
		else
			tx_b = k[0] ? rword[7:0] : rword[15:8];
	end

	// =====================================================
	// frame engine
	wire        sil_go = ser_q && !bcast;
	srv_state_t after;
	assign after = bcast ? S_RX : sil_go ? S_GAP : S_TX;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			st_q <= S_RX;
			rx_n_q <= 9'h000;
			ovf_q <= 1'b0;
			crc_q <= `CRC_INIT;
			ser_q <= 1'b0;
			conn_q <= 2'h0;
			exc_q <= 8'h00;
			last_exc_q <= 8'h00;
			wi_q <= 8'h00;
			tx_i_q <= 9'h000;
			gap_q <= 32'h0;
			lnk.srv_rdy <= 1'b0;
			lnk.rsp_valid <= 1'b0;
			lnk.rsp_data <= 8'h00;
			lnk.rsp_last <= 1'b0;
		end
		else
		begin
			lnk.rsp_valid <= 1'b0;
			lnk.rsp_last <= 1'b0;
			unique case (st_q)
				S_RX:
				begin
					lnk.srv_rdy <= !(lnk.req_valid && lnk.req_last);
					if (lnk.req_valid)
					begin
						if (rx_n_q < `TCP_MAX)
						begin
							buf_q[rx_n_q] <= lnk.req_data;
							rx_n_q <= rx_n_q + 9'h001;
						end
						else
							ovf_q <= 1'b1;
						crc_q <= crc16_step(crc_q, lnk.req_data);
						if (lnk.req_last)
						begin
							ser_q <= lnk.req_ser;
							conn_q <= lnk.req_conn;
							st_q <= S_CHK;
						end
					end
				end
				S_CHK:
				begin
					crc_q <= `CRC_INIT;
					exc_q <= exc_d;
					wi_q <= 8'h00;
					tx_i_q <= 9'h000;
					gap_q <= SIL[32*cfg_q[`F_BAUD +: 3] +: 32];
					if (good)
						last_exc_q <= exc_d;
					if (!good)
						st_q <= S_RX;
					else if (exc_d == 8'h00 && is_wr)
						st_q <= S_EXEC;
					else
						st_q <= after;
				end
				S_EXEC:
				begin
					wi_q <= wi_q + 8'h01;
					if (w_end)
						st_q <= after;
				end
				S_GAP:
				begin
					gap_q <= gap_q - 32'h1;
					if (gap_q <= 32'h1)
						st_q <= S_TX;
				end
				S_TX:
				begin
					lnk.rsp_valid <= 1'b1;
					lnk.rsp_data <= tx_b;
					lnk.rsp_last <= tx_i_q == tlen - 9'h001;
					// crc bytes stay out of the sum, else the high byte goes out wrong
					if (tx_i_q < pend)
						crc_q <= crc16_step(crc_q, tx_b);
					tx_i_q <= tx_i_q + 9'h001;
					if (tx_i_q == tlen - 9'h001)
						st_q <= S_RX;
				end
			endcase
			if (st_q != S_RX && st_q != S_CHK && st_q != S_TX)
				lnk.srv_rdy <= 1'b0;
			if ((st_q == S_TX && tx_i_q == tlen - 9'h001) || (st_q == S_CHK && !good) ||
				(st_q != S_RX && after == S_RX && (st_q == S_CHK ? good && !(exc_d == 8'h00
				&& is_wr) : st_q == S_EXEC && w_end)))
			begin
				rx_n_q <= 9'h000;
				ovf_q <= 1'b0;
				crc_q <= `CRC_INIT;
				lnk.srv_rdy <= 1'b1;
			end
		end
	end

	// =====================================================
	// holding registers: the link write wins over software
	wire hsel = addr[7:6] == `A_HREG && {28'h0, addr[5:2]} < 32'(NREG);

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < NREG; i++)
				hreg_q[i] <= 16'h0000;
		end
		else if (st_q == S_EXEC)
			hreg_q[wa] <= {buf_q[wb], buf_q[wb + 9'h001]};
		else if (wr && hsel)
			hreg_q[addr[5:2]] <= wdata;
	end

	// =====================================================
	// connections
	wire        p_std = lnk.conn_port == `STD_PORT;
	wire        p_usr = cfg_q[`F_UEN] && lnk.conn_port == uport_q;
	wire        c_ok  = has_free && (p_std ?
		n_std < (cfg_q[`F_UEN] ? `CONN_HALF : `CONN_ALL) : p_usr && n_usr < `CONN_HALF);

	always_comb
	begin
		n_std = 3'h0;
		n_usr = 3'h0;
		free = 2'h0;
		has_free = 1'b0;
		for (int i = 3; i >= 0; i--)
		begin
			if (!used_q[i])
			begin
				free = 2'(i);
				has_free = 1'b1;
			end
			n_std = n_std + {2'h0, used_q[i] & !usr_q[i]};
			n_usr = n_usr + {2'h0, used_q[i] & usr_q[i]};
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			used_q <= 4'h0;
			usr_q <= 4'h0;
			lnk.conn_ack <= 1'b0;
			lnk.conn_nak <= 1'b0;
			lnk.conn_id <= 2'h0;
		end
		else
		begin
			if (lnk.conn_rel)
				used_q[lnk.conn_rel_id] <= 1'b0;
			lnk.conn_ack <= lnk.conn_req && c_ok;
			lnk.conn_nak <= lnk.conn_req && !c_ok;
			if (lnk.conn_req)
				lnk.conn_id <= free;
			if (lnk.conn_req && c_ok)
			begin
				used_q[free] <= 1'b1;
				usr_q[free] <= !p_std;
			end
		end
	end

	// =====================================================
	// configuration, supervision, software read
	wire       sup_clr  = st_q == S_CHK && good;
	wire       step_end = tick_q >= 32'(SUP_STEP_CYC - 1);
	wire [7:0] sw_sta   = wdata[7:0];

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			cfg_q <= `CFG_DEF;
			uport_q <= `UPORT_DEF;
			sta_q <= `STA_DEF;
			sup_q <= `SUP_DEF;
			tick_q <= 32'h0;
			steps_q <= 16'h0000;
			sup_to_q <= 1'b0;
			rdata <= 16'h0000;
			ser_parity <= 2'h1;
			ser_baud <= 3'h4;
		end
		else
		begin
			if (wr && addr == `A_CFG)
				cfg_q <= wdata & 16'h073F;
			if (wr && addr == `A_UPORT && wdata >= `UPORT_MIN)
				uport_q <= wdata;
			if (wr && addr == `A_STA && sw_sta != 8'h00 && sw_sta <= `STA_MAX)
				sta_q <= sw_sta;
			if (wr && addr == `A_SUP)
				sup_q <= wdata;
			ser_parity <= cfg_q[`F_PAR +: 2];
			ser_baud <= cfg_q[`F_BAUD +: 3];
			tick_q <= (sup_clr || step_end) ? 32'h0 : tick_q + 32'h1;
			if (sup_clr)
			begin
				steps_q <= 16'h0000;
				sup_to_q <= 1'b0;
			end
			else if (step_end && steps_q != 16'hFFFF)
				steps_q <= steps_q + 16'h0001;
			if (sup_q != 16'h0000 && steps_q >= sup_q)
				sup_to_q <= 1'b1;
			rdata <= !rd ? 16'h0000 :
				addr == `A_CFG ? cfg_q :
				addr == `A_UPORT ? uport_q :
				addr == `A_STA ? {8'h00, sta_q} :
				addr == `A_SUP ? sup_q :
				addr == `A_STAT ? {sup_to_q, 3'h0, used_q, last_exc_q} :
				hsel ? hreg_q[addr[5:2]] : 16'h0000;
		end
	end
endmodule

// [rtl/modbus_client.sv]
`timescale 1ns/1ps
`include "mb_params.svh"
module modbus_client
	import mb_pkg::*;
#(
	parameter int CLK_HZ     = `CLK_HZ,
	parameter int BAUD       = 19200,
	parameter int RSP_TO_CYC = 1000000,
	parameter int NDAT       = 123
)(
	input  wire logic        clk,
	input  wire logic        rst_b,
	mb_link.cli              lnk,
	input  wire logic        open_req,
	input  wire logic [15:0] open_port,
	output logic             open_ok,
	output logic             open_nak,
	output logic      [1:0]  open_id,
	input  wire logic        close_req,
	input  wire logic [1:0]  close_id,
	input  wire logic        dat_we,
	input  wire logic [6:0]  dat_idx,
	input  wire logic [15:0] dat_wdata,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_func,
	input  wire logic [15:0] cmd_addr,
	input  wire logic [15:0] cmd_qty,
	input  wire logic        cmd_ser,
	input  wire logic [1:0]  cmd_conn,
	input  wire logic [7:0]  cmd_unit,
	output logic             cmd_rdy,
	output logic             cmd_bad,
	output logic             rx_valid,
	output logic      [7:0]  rx_data,
	output logic             rx_last,
	output logic             rsp_lost
);
	if (NDAT < 1 || NDAT > 123 || BAUD < 1)
	begin
		$error("NDAT must lie in 1..123");
	end
	// eleven-bit characters, 3.5 of them, rounded up
	localparam longint SIL = (longint'(CLK_HZ) * `CHAR_BITS * `SIL_X2 + 2 * BAUD - 1)
		/ (2 * BAUD);

	cli_state_t  st_q;
	logic [15:0] dat_q [0:NDAT-1];
	logic [7:0]  fc_q, unit_q, tx_b;
	logic [15:0] a_q, q_q, tid_q, crc_q;
	logic        ser_q;
	logic [8:0]  i_q;
	logic [31:0] cnt_q;

	wire [8:0]  h     = ser_q ? `SER_HDR : `TCP_HDR;
	wire        wn    = fc_q == `FC_WRN;
	wire        w1    = fc_q == `FC_WR1;
	wire [8:0]  plen  = wn ? 9'h006 + {q_q[7:0], 1'b0} : 9'h005;
	wire [8:0]  pend  = h + plen;
	wire [8:0]  tlen  = ser_q ? pend + 9'h002 : pend;
	wire [8:0]  k     = i_q - h;
	wire [7:0]  di    = k[8:1] - 8'h03;
	wire [15:0] dw    = (w1 || k < 9'h006) ? dat_q[0] : dat_q[di[6:0]];
	wire        take  = cmd_valid && cmd_rdy;
	wire        bad   = (cmd_func == `FC_RD && cmd_qty > `MAX_RD) ||
		(cmd_func == `FC_WRN && (cmd_qty > `MAX_WR || cmd_qty > 16'(NDAT)));
	wire        t_end = i_q == tlen - 9'h001;

	always_comb
	begin
		if (i_q < h)
			tx_b = ser_q ? unit_q : i_q == 9'h000 ? tid_q[15:8] : i_q == 9'h001 ? tid_q[7:0] :
				i_q == 9'h005 ? 8'(plen + 9'h001) : i_q == 9'h006 ? unit_q : 8'h00;
		else if (i_q >= pend)
			tx_b = i_q == pend ? crc_q[7:0] : crc_q[15:8];
		else if (k == 9'h000)
			tx_b = fc_q;
		else if (k <= 9'h002)
			tx_b = k[0] ? a_q[15:8] : a_q[7:0];
		else if (k <= 9'h004 && !w1)
			tx_b = k[0] ? q_q[15:8] : q_q[7:0];
		else if (k == 9'h005)
			tx_b = {q_q[6:0], 1'b0};
		else
			tx_b = k[0] ^ w1 ? dw[7:0] : dw[15:8];
	end

	always_ff @(posedge clk)
	begin
		if (dat_we && {25'h0, dat_idx} < 32'(NDAT))
			dat_q[dat_idx] <= dat_wdata;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			st_q <= C_IDLE;
			{fc_q, unit_q, a_q, q_q, tid_q, ser_q} <= '0;
			crc_q <= `CRC_INIT;
			i_q <= 9'h000;
			cnt_q <= 32'h0;
			{cmd_rdy, cmd_bad, rx_valid, rx_last, rsp_lost} <= '0;
			rx_data <= 8'h00;
			{open_ok, open_nak, open_id} <= '0;
			{lnk.conn_req, lnk.conn_rel, lnk.conn_port, lnk.conn_rel_id} <= '0;
			{lnk.req_valid, lnk.req_data, lnk.req_last, lnk.req_ser, lnk.req_conn} <= '0;
		end
		else
		begin
			lnk.conn_req <= open_req;
			lnk.conn_port <= open_port;
			lnk.conn_rel <= close_req;
			lnk.conn_rel_id <= close_id;
			open_ok <= lnk.conn_ack;
			open_nak <= lnk.conn_nak;
			open_id <= lnk.conn_id;
			cmd_bad <= take && bad;
			rx_valid <= 1'b0;
			rx_last <= 1'b0;
			rsp_lost <= 1'b0;
			lnk.req_valid <= 1'b0;
			lnk.req_last <= 1'b0;
			cmd_rdy <= st_q == C_IDLE && lnk.srv_rdy && !take;
			unique case (st_q)
				C_IDLE:
				begin
					if (take && !bad)
					begin
						{fc_q, a_q, q_q, ser_q, unit_q} <= {cmd_func, cmd_addr, cmd_qty,
							cmd_ser, cmd_unit};
						lnk.req_ser <= cmd_ser;
						lnk.req_conn <= cmd_conn;
						crc_q <= `CRC_INIT;
						i_q <= 9'h000;
						st_q <= C_TX;
					end
				end
				C_TX:
				begin
					lnk.req_valid <= 1'b1;
					lnk.req_data <= tx_b;
					lnk.req_last <= t_end;
					// crc bytes stay out of the sum, else the high byte goes out wrong
					if (i_q < pend)
						crc_q <= crc16_step(crc_q, tx_b);
					i_q <= i_q + 9'h001;
					cnt_q <= 32'h0;
					if (t_end)
					begin
						if (!ser_q)
							tid_q <= tid_q + 16'h0001;
						st_q <= (ser_q && unit_q == `BCAST) ? C_GAP : C_WAIT;
					end
				end
				C_WAIT:
				begin
					cnt_q <= cnt_q + 32'h1;
					rx_valid <= lnk.rsp_valid;
					rx_data <= lnk.rsp_data;
					rx_last <= lnk.rsp_valid && lnk.rsp_last;
					if (lnk.rsp_valid && lnk.rsp_last)
					begin
						cnt_q <= 32'h0;
						st_q <= ser_q ? C_GAP : C_IDLE;
					end
					else if (cnt_q >= 32'(RSP_TO_CYC - 1))
					begin
						rsp_lost <= 1'b1;
						st_q <= C_IDLE;
					end
				end
				C_GAP:
				begin
					cnt_q <= cnt_q + 32'h1;
					if (cnt_q >= 32'(SIL - 1))
					begin
						cnt_q <= 32'h0;
						st_q <= C_IDLE;
					end
				end
			endcase
		end
	end
endmodule

// [verif/mb_link_assertions.sv]
`timescale 1ns/1ps
module mb_link_assertions (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic conn_req,
	input wire logic conn_ack,
	input wire logic conn_nak,
	input wire logic srv_rdy,
	input wire logic req_valid,
	input wire logic req_last,
	input wire logic req_ser,
	input wire logic rsp_valid,
	input wire logic rsp_last
);
	logic [8:0] cnt_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ==========
	// byte index inside the request in flight
	always_ff @(posedge clk)
		if (!rst_b)
			cnt_q <= 9'h000;
		else if (req_valid)
			cnt_q <= req_last ? 9'h000 : cnt_q + 9'h001;
	// ==========
	// link relations
	a_conn_answer: assert property (conn_req |=> conn_ack ^ conn_nak)
		else $error("connection request left unanswered");
	a_ack_nak_excl: assert property (!(conn_ack && conn_nak))
		else $error("ack and nak together");
	a_rsp_when_busy: assert property (rsp_valid && !rsp_last |-> !srv_rdy)
		else $error("response while server idle");
	a_rdy_after_last: assert property (rsp_valid && rsp_last |-> srv_rdy ##1 srv_rdy)
		else $error("server not idle after response");
	a_rsp_burst: assert property (rsp_valid && !rsp_last |=> rsp_valid)
		else $error("gap inside response");
	a_last_valid: assert property (rsp_last |-> rsp_valid)
		else $error("response last without byte");
	a_req_idle: assert property ($rose(req_valid) |-> srv_rdy)
		else $error("request started while server busy");
	a_tcp_turn: assert property (req_valid && req_last && !req_ser |-> ##[2:130] rsp_valid)
		else $error("tcp request not answered in time");
	a_tcp_size: assert property (req_valid && !req_ser |-> cnt_q < 9'h104)
		else $error("tcp request longer than limit");
endmodule

// [verif/modbus_register_server_bench.sv]
`timescale 1ns/1ps
module modbus_register_server_bench;
	import mb_pkg::*;
	// ==========
	// stimulus and observed signals
	logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, open_req = 1'b0;
	logic        dat_we = 1'b0, cmd_valid = 1'b0, cmd_ser = 1'b0, close_req = 1'b0;
	logic        open_ok, open_nak, cmd_rdy, cmd_bad, rx_valid, rx_last, rsp_lost;
	logic [1:0]  cmd_conn = 2'h0, close_id = 2'h0, open_id, ser_parity;
	logic [2:0]  ser_baud;
	logic [6:0]  dat_idx = 7'h00;
	logic [7:0]  addr = 8'h00, cmd_func = 8'h00, cmd_unit = 8'h01, rx_data;
	logic [15:0] wdata = 16'h0000, dat_wdata = 16'h0000, open_port = 16'h0000, rdata;
	logic [15:0] cmd_addr = 16'h0000, cmd_qty = 16'h0000;
	logic [15:0] dw[4];
	int          hr[16];
	int          fail_count = 0, tests_run = 0, i;
	mb_link lnk();
	modbus_server #(.CLK_HZ(1000000), .SUP_STEP_CYC(20)) u_modbus_server (.clk(clk),
		.rst_b(rst_b), .lnk(lnk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .ser_parity(ser_parity), .ser_baud(ser_baud));
	modbus_client #(.CLK_HZ(1000000), .RSP_TO_CYC(20000)) u_modbus_client (.clk(clk),
		.rst_b(rst_b), .lnk(lnk), .open_req(open_req), .open_port(open_port),
		.open_ok(open_ok), .open_nak(open_nak), .open_id(open_id), .close_req(close_req),
		.close_id(close_id), .dat_we(dat_we), .dat_idx(dat_idx), .dat_wdata(dat_wdata),
		.cmd_valid(cmd_valid), .cmd_func(cmd_func), .cmd_addr(cmd_addr), .cmd_qty(cmd_qty),
		.cmd_ser(cmd_ser), .cmd_conn(cmd_conn), .cmd_unit(cmd_unit), .cmd_rdy(cmd_rdy),
		.cmd_bad(cmd_bad), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
		.rsp_lost(rsp_lost));
	mb_link_assertions u_mb_link_assertions (.clk(clk), .rst_b(rst_b),
		.conn_req(lnk.conn_req), .conn_ack(lnk.conn_ack), .conn_nak(lnk.conn_nak),
		.srv_rdy(lnk.srv_rdy), .req_valid(lnk.req_valid), .req_last(lnk.req_last),
		.req_ser(lnk.req_ser), .rsp_valid(lnk.rsp_valid), .rsp_last(lnk.rsp_last));
	always #10 clk = ~clk;
	// ==========
	// shared tasks
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// extra idle edge keeps two strobe writes out of one time step
	task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic bus_rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] x);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		check(rdata & m, x);
	endtask
	task automatic open(input logic [15:0] p, input logic ok, input logic [1:0] id);
		int n;
		open_port <= p;
		open_req <= 1'b1;
		@(posedge clk);
		open_req <= 1'b0;
		for (n = 0; n < 8 && open_ok !== 1'b1 && open_nak !== 1'b1; n++)
			@(posedge clk);
		check(16'(open_ok), 16'(ok));
		check(16'(open_nak), 16'(!ok));
		if (ok)
			check(16'(open_id), 16'(id));
	endtask
	// model: expected pdu from the holding array, then compare with the client copy
	task automatic xact(input logic [7:0] f, input int a, q, input logic s,
		input logic [1:0] c, input int r, m, b);
		int e, n, lo;
		logic [15:0] hv, cr;
		logic [7:0]  exp[$];
		logic [7:0]  got[$];
		for (n = 0; n < 4; n++)
		begin
			dw[n] = 16'($urandom);
			if (n == 1)
				dw[n][7:0] = 8'(m);
			dat_idx <= 7'(n);
			dat_wdata <= dw[n];
			dat_we <= 1'b1;
			@(posedge clk);
		end
		dat_we <= 1'b0;
		cmd_func <= f;
		cmd_addr <= 16'(a);
		cmd_qty <= 16'(q);
		cmd_ser <= s;
		cmd_conn <= c;
		cmd_valid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (cmd_rdy !== 1'b1 && n < 5000);
		cmd_valid <= 1'b0;
		e = 0;
		if (b)
		begin
			for (n = 0; n < 3; n++)
			begin
				@(posedge clk);
				e |= (cmd_bad === 1'b1);
			end
			check(16'(e), 16'h0001);
			return;
		end
		lo = a + q;
		if (f != 8'h03 && f != 8'h06 && f != 8'h10)
			e = 1;
		else if (q == 0 || lo > 16 || (f != 8'h03 && a < 8))
			e = 2;
		else if ((a < 8 && a % 2) || (lo < 8 && lo % 2) || (f != 8'h03 && r)
			|| (a < 12 && lo > 8 && (a > 8 || lo < 12)))
			e = 3;
		else if (f == 8'h10 && a <= 9 && lo > 9 && (dw[9 - a][7:0] == 0 || dw[9 - a][7:0] > 12))
			e = 4;
		hv = (f == 8'h06) ? dw[0] : 16'(q);
		if (e != 0)
			exp = {f | 8'h80, 8'(e)};
		else if (f == 8'h03)
		begin
			exp = {f, 8'(2 * q)};
			for (n = a; n < lo; n++)
				exp = {exp, 8'(hr[n] >> 8), 8'(hr[n])};
		end
		else
		begin
			exp = {f, 8'(a >> 8), 8'(a), hv[15:8], hv[7:0]};
			for (n = 0; n < q; n++)
				hr[a + n] = dw[n];
		end
		for (n = 0; n < 9000; n++)
		begin
			@(posedge clk);
			if (rx_valid === 1'b1)
				got.push_back(rx_data);
			if (rx_valid === 1'b1 && rx_last === 1'b1)
				n = 9999;
		end
		if (s)
		begin
			cr = 16'hFFFF;
			foreach (got[j])
			begin
				cr ^= {8'h00, got[j]};
				repeat (8)
					cr = cr[0] ? ((cr >> 1) ^ 16'hA001) : (cr >> 1);
			end
			check(cr, 16'h0000);
		end
		n = s ? 1 : 7;
		if (s)
			check(16'(got[0]), 16'(cmd_unit));
		else
			check(16'(got[5]), 16'(exp.size() + 1));
		check(16'(got.size()), 16'(exp.size() + n + (s ? 2 : 0)));
		for (lo = 0; lo < exp.size(); lo++)
			check(16'(got[lo + n]), 16'(exp[lo]));
		bus_rd(8'h10, 16'h00FF, 16'(e));
	endtask
	// ==========
	// sequence
	initial
	begin
		#(20 * 80000);
		fail_count++;
		final_report;
	end
	initial
	begin
		void'($urandom(32'hEF0452AC));
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		check(16'(ser_parity), 16'h0001);
		check(16'(ser_baud), 16'h0004);
		bus_rd(8'h00, 16'hFFFF, 16'h0410);
		bus_rd(8'h04, 16'hFFFF, 16'h2710);
		bus_rd(8'h24, 16'hFFFF, 16'h0000);
		for (i = 0; i < 16; i++)
		begin
			hr[i] = $urandom % 65536;
			bus_wr(8'(64 + 4 * i), 16'(hr[i]));
		end
		bus_wr(8'h00, 16'h0411);
		open(16'h01F6, 1'b1, 2'h0);
		open(16'h01F6, 1'b1, 2'h1);
		open(16'h01F6, 1'b0, 2'h0);
		open(16'h2710, 1'b1, 2'h2);
		bus_rd(8'h10, 16'h0F00, 16'h0700);
		close_id <= 2'h1;
		close_req <= 1'b1;
		@(posedge clk);
		close_req <= 1'b0;
		repeat (2) @(posedge clk);
		bus_rd(8'h10, 16'h0F00, 16'h0500);
		open(16'h01F6, 1'b1, 2'h1);
		xact(8'h10, 12, 4, 0, 0, 0, 5, 0);
		xact(8'h03, 12, 4, 0, 1, 0, 0, 0);
		xact(8'h03, 0, 8, 0, 0, 0, 0, 0);
		xact(8'h03, 1, 2, 0, 0, 0, 0, 0);
		xact(8'h03, 15, 2, 0, 0, 0, 0, 0);
		xact(8'h03, 0, 0, 0, 0, 0, 0, 0);
		xact(8'h03, 0, 125, 0, 0, 0, 0, 0);
		xact(8'h10, 0, 123, 0, 2, 0, 0, 0);
		xact(8'h06, 3, 1, 0, 0, 0, 0, 0);
		xact(8'h06, 9, 1, 0, 0, 0, 0, 0);
		xact(8'h10, 8, 4, 0, 0, 0, 12, 0);
		xact(8'h10, 8, 4, 0, 0, 0, 13, 0);
		xact(8'h10, 8, 4, 0, 0, 0, 0, 0);
		xact(8'h03, 8, 4, 0, 0, 0, 0, 0);
		xact(8'h03, 12, 2, 1, 0, 0, 0, 0);
		bus_wr(8'h08, 16'h00F7);
		bus_wr(8'h08, 16'h00F8);
		bus_rd(8'h08, 16'hFFFF, 16'h00F7);
		cmd_unit <= 8'hF7;
		xact(8'h03, 12, 2, 1, 0, 0, 0, 0);
		xact(8'h03, 0, 126, 0, 0, 0, 0, 1);
		xact(8'h10, 12, 124, 0, 0, 0, 0, 1);
		xact(8'h01, 12, 1, 0, 0, 0, 0, 0);
		xact(8'h04, 12, 1, 0, 0, 0, 0, 0);
		xact(8'h2B, 12, 1, 0, 0, 0, 0, 0);
		bus_wr(8'h00, 16'h0413);
		xact(8'h06, 12, 1, 0, 0, 1, 0, 0);
		xact(8'h06, 12, 1, 0, 2, 0, 0, 0);
		xact(8'h10, 12, 2, 1, 0, 0, 0, 0);
		bus_wr(8'h00, 16'h041B);
		xact(8'h10, 12, 2, 1, 0, 1, 0, 0);
		bus_wr(8'h0C, 16'h0002);
		repeat (60) @(posedge clk);
		bus_rd(8'h10, 16'h8000, 16'h8000);
		bus_wr(8'h0C, 16'h0000);
		xact(8'h03, 12, 4, 0, 2, 0, 0, 0);
		repeat (60) @(posedge clk);
		bus_rd(8'h10, 16'h8000, 16'h0000);
		final_report;
	end
endmodule
